// ===== rtl/rxja_pkg.sv
/*
 Constants of the receive jitter attenuator: register offsets, field positions,
 reset values, FIFO depths, limit thresholds and loop constants.
 Assumes a 125 MHz mclk and an 8-bit register port per link.
*/
package rxja_pkg;
   // Register offsets inside one link's page
   localparam logic [7:0] OFS_ATTEN_CONFIG = 8'h27;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h34;
   localparam logic [7:0] OFS_MEASURE_VALUE = 8'h39;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h3b;
   localparam logic [7:0] OFS_REF_CLOCK_CTRL = 8'h3e;
   // Attenuator configuration fields
   localparam int CFG_ENABLE_BIT = 0;
   localparam int CFG_DEPTH_LSB = 1;
   localparam int CFG_BANDWIDTH_BIT = 3;
   localparam int CFG_LIMIT_BIT = 4;
   localparam int CFG_PEAK_MODE_BIT = 5;
   // Interrupt enable, status and reference clock fields
   localparam int IRQ_ATTEN_BIT = 0;
   localparam int STAT_LOSS_BIT = 1;
   localparam int REF_FALLBACK_BIT = 0;
   localparam int REF_A_SEL_LSB = 2;
   localparam int REF_B_SEL_LSB = 4;
   // Reset values
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] REF_CTRL_RESET = 8'h00;
   // Depth select codes and depths in bit positions
   localparam logic [1:0] DEPTH_SEL_32 = 2'h0;
   localparam logic [1:0] DEPTH_SEL_64 = 2'h1;
   localparam logic [7:0] DEPTH_32 = 8'h20;
   localparam logic [7:0] DEPTH_64 = 8'h40;
   localparam logic [7:0] DEPTH_128 = 8'h80;
   // Distance from full or empty at which rate adjustment starts
   localparam logic [7:0] LIMIT_THR_32 = 8'h02;
   localparam logic [7:0] LIMIT_THR_64 = 8'h03;
   localparam logic [7:0] LIMIT_THR_128 = 8'h04;
   // Corner frequencies in units of 0.01 Hz
   localparam int CF_T1_WIDE_CHZ = 500;
   localparam int CF_T1_NARROW_CHZ = 126;
   localparam int CF_E1_WIDE_CHZ = 677;
   localparam int CF_E1_NARROW_CHZ = 87;
   // Integral gain shifts; a larger shift gives a lower corner
   localparam logic [4:0] KI_SHIFT_T1_WIDE = 5'h0a;
   localparam logic [4:0] KI_SHIFT_T1_NARROW = 5'h0c;
   localparam logic [4:0] KI_SHIFT_E1_WIDE = 5'h0a;
   localparam logic [4:0] KI_SHIFT_E1_NARROW = 5'h0d;
   localparam int KI_SCALE = 12;
   localparam int KP_SHIFT = 6;
   localparam int LIMIT_STEP_SHIFT = 3;
   // Read clock oscillator, 24-bit phase accumulator on mclk
   localparam int NCO_BITS = 24;
   localparam longint MCLK_KHZ = 125000;
   localparam longint T1_RATE_KHZ = 1544;
   localparam longint E1_RATE_KHZ = 2048;
   localparam logic [23:0] NOM_STEP_T1 = 24'((T1_RATE_KHZ * (64'd1 << NCO_BITS)) / MCLK_KHZ);
   localparam logic [23:0] NOM_STEP_E1 = 24'((E1_RATE_KHZ * (64'd1 << NCO_BITS)) / MCLK_KHZ);
endpackage : rxja_pkg

// ===== rtl/rxja_bit_mem.sv
/*
 One-bit-wide FIFO store of the attenuator, with registered read data.
 Assumes the caller keeps addresses below DEPTH.
*/
`timescale 1ns/100ps
module rxja_bit_mem #(
   parameter int DEPTH = 128,
   parameter int AW = 7
) (
   input wire logic mclk,
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic wrData,
   input wire logic rdEn,
   input wire logic [AW-1:0] rdAddr,
   output logic rdData
);
   logic [DEPTH-1:0] store;

   generate
      if (DEPTH > (1 << AW)) begin : g_bad
         $error("rxja_bit_mem: DEPTH exceeds address range");
      end
   endgenerate

   // Write port
   always_ff @(posedge mclk) begin
      if (wrEn) begin
         store[wrAddr] <= wrData;
      end
   end

   // Read port; data one cycle after the enable
   always_ff @(posedge mclk) begin
      if (rdEn) begin
         rdData <= store[rdAddr];
      end
   end
endmodule : rxja_bit_mem

// ===== rtl/rxja_top.sv
/*
 Receive jitter attenuator of one link, with the two reference clock selectors.
 Assumes recovered bit strobes, link clocks and loss flags are synchronous to mclk,
 and a register port with one-cycle write and read strobes.
*/
// Behaviour
// RL1: Per-link enable bit inserts or bypasses the attenuator.
// RL2: Two-bit field selects FIFO depth of 32, 64 or 128.
// RL3: Latency is half the selected depth.
// RL4: Write on recovered strobe, read on smoothed loop-generated strobe.
// RL5: T1/J1 bandwidth bit selects 5 Hz or 1.26 Hz corner.
// RL6: E1 bandwidth bit selects 6.77 Hz or 0.87 Hz corner.
// RL7: Only jitter above the corner is filtered.
// RL8: Overflow or underflow sets a latched status flag.
// RL9: Flag with its enable drives the active-low interrupt.
// RL10: Limit bit speeds or slows reads near full or empty.
// RL11: Adjustment starts 2, 3 or 4 positions from the ends.
// RL12: Measure mode 0 writes live pointer distance to seven bits.
// RL13: Measure mode 1 keeps the larger distance (peak hold).
// RL14: Two reference outputs each pick one of four link clocks.
// RL15: On loss, output carries master clock or high per fallback bit.
// RL16: Recovered strobe keeps data phase, also without pulses.
// RL17: Per-link loss status bit readable; drives the fallback.
// RL18: Enable or reset starts pointers half the depth apart.
`timescale 1ns/100ps
module rxja_top #(
   parameter int LINK_ID = 0,
   parameter int MAX_DEPTH = 128
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [9:0] regAddr,
   input wire logic regWrEn,
   input wire logic [7:0] regWrData,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   input wire logic e1Mode,
   input wire logic rxBit,
   input wire logic rxBitStrobe,
   input wire logic [3:0] linkClk,
   input wire logic [3:0] signalLossStatus,
   input wire logic oscillatorInput,
   output logic jaDataOut,
   output logic jaDataStrobe,
   output logic irqN,
   output logic refClockOutA,
   output logic refClockOutB
);
   generate
      if (LINK_ID < 0 || LINK_ID > 3 || MAX_DEPTH != 128) begin : g_bad
         $error("rxja_top: LINK_ID must be 0..3 and MAX_DEPTH 128");
      end
   endgenerate

   localparam logic [1:0] LINK_PAGE = 2'(LINK_ID);

   logic attenEnable_r, attenBandwidthSel_r, attenLimitEnable_r, pointerMeasurePeakMode_r;
   logic [1:0] attenDepthSel_r, depthSelPrev_r, refOutALinkSel_r, refOutBLinkSel_r;
   logic enablePrev_r, attenFlowErrorIrqEn_r, attenFlowErrorFlag_r, refOutFallbackHigh_r;
   logic [6:0] pointerDistanceValue_r, wrPtr_r, rdPtr_r, ptrMask;
   logic [7:0] fill_r, depth, halfDepth, limitThr;
   logic restart, wrReq, rdReq, overflow, underflow, memRdData, readPend_r, rdTick_r;
   logic nearFull, nearEmpty;
   logic [6:0] satFill;
   logic [4:0] kiShift;
   logic [23:0] freqWord_r, phaseAcc_r, stepBase, ncoStep;
   logic signed [24:0] fillErr;
   logic [24:0] phaseSum;
   logic pageHit, resetPrev_r;

   assign pageHit = regAddr[9:8] == LINK_PAGE;

   // Configuration and control registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         attenEnable_r <= 1'b0;
         attenDepthSel_r <= 2'h0;
         attenBandwidthSel_r <= 1'b0;
         attenLimitEnable_r <= 1'b0;
         pointerMeasurePeakMode_r <= 1'b0;
         attenFlowErrorIrqEn_r <= 1'b0;
         refOutFallbackHigh_r <= 1'b0;
         refOutALinkSel_r <= 2'h0;
         refOutBLinkSel_r <= 2'h0;
      end else if (regWrEn && pageHit) begin
         case (regAddr[7:0])
            rxja_pkg::OFS_ATTEN_CONFIG: begin
               attenEnable_r <= regWrData[rxja_pkg::CFG_ENABLE_BIT]; // RL1
               attenDepthSel_r <= regWrData[rxja_pkg::CFG_DEPTH_LSB +: 2];
               attenBandwidthSel_r <= regWrData[rxja_pkg::CFG_BANDWIDTH_BIT];
               attenLimitEnable_r <= regWrData[rxja_pkg::CFG_LIMIT_BIT];
               pointerMeasurePeakMode_r <= regWrData[rxja_pkg::CFG_PEAK_MODE_BIT];
            end
            rxja_pkg::OFS_IRQ_ENABLE: begin
               attenFlowErrorIrqEn_r <= regWrData[rxja_pkg::IRQ_ATTEN_BIT];
            end
            rxja_pkg::OFS_REF_CLOCK_CTRL: begin
               refOutFallbackHigh_r <= regWrData[rxja_pkg::REF_FALLBACK_BIT];
               refOutALinkSel_r <= regWrData[rxja_pkg::REF_A_SEL_LSB +: 2];
               refOutBLinkSel_r <= regWrData[rxja_pkg::REF_B_SEL_LSB +: 2];
            end
            default: begin
            end
         endcase
      end
   end

   // Depth, half depth and limit threshold from the select field
   always_comb begin
      case (attenDepthSel_r)
         rxja_pkg::DEPTH_SEL_32: begin
            depth = rxja_pkg::DEPTH_32; // RL2
            limitThr = rxja_pkg::LIMIT_THR_32; // RL11
         end
         rxja_pkg::DEPTH_SEL_64: begin
            depth = rxja_pkg::DEPTH_64;
            limitThr = rxja_pkg::LIMIT_THR_64;
         end
         default: begin
            depth = rxja_pkg::DEPTH_128;
            limitThr = rxja_pkg::LIMIT_THR_128;
         end
      endcase
      halfDepth = depth >> 1; // RL3
      ptrMask = 7'(depth - 8'h01);
   end

   // Any enable rise or depth change restarts the FIFO centred
   always_ff @(posedge mclk) begin
      if (reset) begin
         enablePrev_r <= 1'b0;
         depthSelPrev_r <= 2'h0;
      end else begin
         enablePrev_r <= attenEnable_r;
         depthSelPrev_r <= attenDepthSel_r;
      end
   end
   assign restart = (attenEnable_r && !enablePrev_r) || (attenDepthSel_r != depthSelPrev_r);

   // Recovered strobe writes, loop tick reads; flow errors recentre
   assign wrReq = attenEnable_r && rxBitStrobe; // RL4 RL16
   assign rdReq = attenEnable_r && rdTick_r; // RL4
   assign overflow = wrReq && !rdReq && fill_r == depth; // RL8
   assign underflow = rdReq && !wrReq && fill_r == 8'h00; // RL8

   always_ff @(posedge mclk) begin
      if (reset || restart || overflow || underflow) begin
         wrPtr_r <= 7'(halfDepth); // RL18
         rdPtr_r <= 7'h00;
         fill_r <= halfDepth; // RL3
      end else begin
         if (wrReq) begin
            wrPtr_r <= (wrPtr_r + 7'h01) & ptrMask;
         end
         if (rdReq) begin
            rdPtr_r <= (rdPtr_r + 7'h01) & ptrMask;
         end
         if (wrReq && !rdReq) begin
            fill_r <= fill_r + 8'h01;
         end else if (rdReq && !wrReq) begin
            fill_r <= fill_r - 8'h01;
         end
      end
   end

   rxja_bit_mem #(
      .DEPTH(MAX_DEPTH),
      .AW(7)
   ) u_mem (
      .mclk(mclk),
      .wrEn(wrReq && !overflow),
      .wrAddr(wrPtr_r),
      .wrData(rxBit),
      .rdEn(rdReq && !underflow),
      .rdAddr(rdPtr_r),
      .rdData(memRdData)
   );

   // Output stage; bypass passes the recovered bit straight through
   always_ff @(posedge mclk) begin
      if (reset) begin
         readPend_r <= 1'b0;
         jaDataOut <= 1'b0;
         jaDataStrobe <= 1'b0;
      end else begin
         readPend_r <= rdReq && !underflow && !restart;
         jaDataOut <= attenEnable_r ? memRdData : rxBit; // RL1
         jaDataStrobe <= attenEnable_r ? readPend_r : rxBitStrobe; // RL1
      end
   end

   // Loop gain from line mode and bandwidth bit
   always_comb begin
      case ({e1Mode, attenBandwidthSel_r})
         2'h0: kiShift = rxja_pkg::KI_SHIFT_T1_WIDE; // RL5
         2'h1: kiShift = rxja_pkg::KI_SHIFT_T1_NARROW; // RL5
         2'h2: kiShift = rxja_pkg::KI_SHIFT_E1_WIDE; // RL6
         default: kiShift = rxja_pkg::KI_SHIFT_E1_NARROW; // RL6
      endcase
   end

   // Fill error drives a proportional-integral loop; slow wander passes
   assign fillErr = $signed({17'h00000, fill_r}) - $signed({17'h00000, halfDepth});
   assign stepBase = freqWord_r + 24'(fillErr <<< rxja_pkg::KP_SHIFT); // RL7
   assign nearFull = fill_r >= depth - limitThr; // RL11
   assign nearEmpty = fill_r <= limitThr; // RL11

   // Limit nudges the read rate, at the cost of jitter quality
   always_comb begin
      ncoStep = stepBase;
      if (attenLimitEnable_r && nearFull) begin
         ncoStep = stepBase + (stepBase >> rxja_pkg::LIMIT_STEP_SHIFT); // RL10
      end else if (attenLimitEnable_r && nearEmpty) begin
         ncoStep = stepBase - (stepBase >> rxja_pkg::LIMIT_STEP_SHIFT); // RL10
      end
   end
   assign phaseSum = {1'b0, phaseAcc_r} + {1'b0, ncoStep};

   // Oscillator and integrator; integrator learns the line rate
   always_ff @(posedge mclk) begin
      if (reset) begin
         phaseAcc_r <= 24'h000000;
         rdTick_r <= 1'b0;
         freqWord_r <= rxja_pkg::NOM_STEP_T1;
      end else if (!attenEnable_r || restart) begin
         phaseAcc_r <= 24'h000000;
         rdTick_r <= 1'b0;
         freqWord_r <= e1Mode ? rxja_pkg::NOM_STEP_E1 : rxja_pkg::NOM_STEP_T1;
      end else begin
         phaseAcc_r <= phaseSum[23:0];
         rdTick_r <= phaseSum[24]; // RL4
         if (rdTick_r) begin
            freqWord_r <= freqWord_r + 24'((fillErr <<< rxja_pkg::KI_SCALE) >>> kiShift); // RL7
         end
      end
   end

   // Pointer distance measurement, saturated to seven bits
   assign satFill = fill_r[7] ? 7'h7f : fill_r[6:0];
   always_ff @(posedge mclk) begin
      if (reset) begin
         pointerDistanceValue_r <= 7'h00;
      end else if (!pointerMeasurePeakMode_r) begin
         pointerDistanceValue_r <= satFill; // RL12
      end else if (satFill > pointerDistanceValue_r) begin
         pointerDistanceValue_r <= satFill; // RL13
      end
   end

   // Sticky flow error; a new error beats a same-cycle clear
   always_ff @(posedge mclk) begin
      if (reset) begin
         attenFlowErrorFlag_r <= 1'b0;
      end else if (overflow || underflow) begin
         attenFlowErrorFlag_r <= 1'b1; // RL8
      end else if (regWrEn && pageHit && regAddr[7:0] == rxja_pkg::OFS_IRQ_STATUS
                   && regWrData[rxja_pkg::IRQ_ATTEN_BIT]) begin
         attenFlowErrorFlag_r <= 1'b0;
      end
   end

   // Interrupt pin, low while flag and enable are both set
   always_ff @(posedge mclk) begin
      if (reset) begin
         irqN <= 1'b1;
      end else begin
         irqN <= !(attenFlowErrorFlag_r && attenFlowErrorIrqEn_r); // RL9
      end
   end

   // Reference clock selectors with loss fallback
   always_ff @(posedge mclk) begin
      if (reset) begin
         refClockOutA <= 1'b0;
         refClockOutB <= 1'b0;
      end else begin
         refClockOutA <= signalLossStatus[refOutALinkSel_r] ? // RL17
            (refOutFallbackHigh_r | oscillatorInput) : linkClk[refOutALinkSel_r]; // RL14 RL15
         refClockOutB <= signalLossStatus[refOutBLinkSel_r] ?
            (refOutFallbackHigh_r | oscillatorInput) : linkClk[refOutBLinkSel_r]; // RL14 RL15
      end
   end

   // Register read-back, data one cycle after the strobe
   always_ff @(posedge mclk) begin
      if (reset) begin
         regRdData <= 8'h00;
      end else if (regRdEn) begin
         regRdData <= 8'h00;
         if (pageHit) begin
            case (regAddr[7:0])
               rxja_pkg::OFS_ATTEN_CONFIG: regRdData <= {2'h0, pointerMeasurePeakMode_r, attenLimitEnable_r,
                  attenBandwidthSel_r, attenDepthSel_r, attenEnable_r};
               rxja_pkg::OFS_IRQ_ENABLE: regRdData <= {7'h00, attenFlowErrorIrqEn_r};
               rxja_pkg::OFS_MEASURE_VALUE: regRdData <= {1'b0, pointerDistanceValue_r}; // RL12
               rxja_pkg::OFS_IRQ_STATUS: regRdData <= {6'h00, signalLossStatus[LINK_ID],
                  attenFlowErrorFlag_r}; // RL17
               rxja_pkg::OFS_REF_CLOCK_CTRL: regRdData <= {2'h0, refOutBLinkSel_r, refOutALinkSel_r,
                  1'b0, refOutFallbackHigh_r};
               default: regRdData <= 8'h00;
            endcase
         end
      end
   end

   // Outputs still show the last reset edge one cycle after release, so checks wait one edge more
   always_ff @(posedge mclk) begin
      resetPrev_r <= reset;
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset || resetPrev_r);

   depth_map_a: assert property (depth == (8'h20 << (attenDepthSel_r[1] ? 2'h2 : {1'b0, attenDepthSel_r[0]})))
      else $error("depth does not follow select"); // RL2
   init_centre_a: assert property ($rose(attenEnable_r) |=> fill_r == halfDepth && wrPtr_r == 7'(halfDepth)
      && rdPtr_r == 7'h00) else $error("restart not centred"); // RL18
   fill_bound_a: assert property (!restart |-> fill_r <= depth) else $error("fill above depth"); // RL3
   flag_set_a: assert property (overflow || underflow |=> attenFlowErrorFlag_r)
      else $error("flow error not latched"); // RL8
   irq_drive_a: assert property (attenFlowErrorFlag_r && attenFlowErrorIrqEn_r |=> !irqN)
      else $error("interrupt not asserted"); // RL9
   bypass_path_a: assert property (!attenEnable_r && rxBitStrobe |=> jaDataStrobe && jaDataOut == $past(rxBit))
      else $error("bypass path broken"); // RL1
   measure_live_a: assert property (!pointerMeasurePeakMode_r |=> pointerDistanceValue_r == $past(satFill))
      else $error("live measure stale"); // RL12
   measure_peak_a: assert property (pointerMeasurePeakMode_r |=> pointerDistanceValue_r >=
      $past(pointerDistanceValue_r) && pointerDistanceValue_r >= $past(satFill))
      else $error("peak hold lost"); // RL13
   ref_fallback_a: assert property (signalLossStatus[refOutALinkSel_r] && refOutFallbackHigh_r |=> refClockOutA)
      else $error("fallback high missing"); // RL15
   limit_fast_a: assert property (attenLimitEnable_r && nearFull && stepBase < 24'he00000 |-> ncoStep > stepBase)
      else $error("limit did not speed up"); // RL10
endmodule : rxja_top

// ===== tb/rxja_cdr_model.sv
/*
 Behavioural clock and data recovery of the receive links: jittered bit strobes,
 four recovered link clocks and loss flags.
 Assumes the bench supplies the next data bit and the loss pattern.
*/
`timescale 1ns/100ps
module rxja_cdr_model (
   input wire logic mclk,
   input wire logic reset,
   input wire logic run,
   input wire logic [7:0] bitPeriod,
   input wire logic bitIn,
   input wire logic [3:0] lossIn,
   output logic rxBit,
   output logic rxBitStrobe,
   output logic [3:0] linkClk,
   output logic [3:0] signalLossStatus
);
   logic [7:0] cnt_r;
   logic late_r;
   logic [3:0] div_r [4];

   // Strobes alternate early and late so the mean rate is bitPeriod
   always_ff @(posedge mclk) begin
      rxBitStrobe <= 1'b0;
      if (reset) begin
         cnt_r <= 8'h00;
         late_r <= 1'b0;
         rxBit <= 1'b0;
      end else if (!run || cnt_r != 8'h00) begin
         cnt_r <= run ? cnt_r - 8'h01 : 8'h00;
         rxBit <= ~rxBit; // Between strobes the bit is not held
      end else begin
         rxBitStrobe <= 1'b1;
         rxBit <= bitIn;
         late_r <= ~late_r;
         cnt_r <= late_r ? bitPeriod + 8'h03 : bitPeriod - 8'h05;
      end
   end

   // Each link clock at its own rate, so a wrong selection shows
   always_ff @(posedge mclk) begin
      for (int i = 0; i < 4; i++) begin
         if (reset || div_r[i] == 4'h0) begin
            div_r[i] <= 4'(i + 1);
            linkClk[i] <= reset ? 1'b0 : ~linkClk[i];
         end else begin
            div_r[i] <= div_r[i] - 4'h1;
         end
      end
      signalLossStatus <= lossIn;
   end
endmodule : rxja_cdr_model

// ===== tb/test_receive_jitter_attenuator.sv
/*
 Self-checking bench of the receive jitter attenuator: registers, reference clocks,
 bypass and FIFO data paths, flow errors, limit function and measurement.
 Assumes link 0 and the behavioural recovery model as the far side.
*/
`timescale 1ns/100ps
module test_receive_jitter_attenuator;
   logic mclk = 1'b0, reset = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0, e1Mode = 1'b0, osc = 1'b0, run = 1'b0;
   logic [9:0] regAddr = 10'h000;
   logic [7:0] regWrData = 8'h00, bitPeriod = 8'h51, rd, regRdData;
   logic [3:0] lossIn = 4'h0, linkClk, signalLossStatus;
   logic [15:0] lfsrState = 16'h38ce;
   logic rxBit, rxBitStrobe, jaDataOut, jaDataStrobe, irqN, refA, refB, expA, expB, fb, refCheck = 1'b0;
   logic [1:0] selA = 2'h0, selB = 2'h0;
   logic [6:0] prev;
   logic q[$];
   int failures = 0, n_tests = 0, inCount, outCount, skip;
   bit checking = 0;

   rxja_top #(.LINK_ID(0), .MAX_DEPTH(128)) uut (.mclk(mclk), .reset(reset), .regAddr(regAddr),
      .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .e1Mode(e1Mode),
      .rxBit(rxBit), .rxBitStrobe(rxBitStrobe), .linkClk(linkClk), .signalLossStatus(signalLossStatus),
      .oscillatorInput(osc), .jaDataOut(jaDataOut), .jaDataStrobe(jaDataStrobe), .irqN(irqN),
      .refClockOutA(refA), .refClockOutB(refB));
   rxja_cdr_model cdr (.mclk(mclk), .reset(reset), .run(run), .bitPeriod(bitPeriod), .bitIn(lfsrState[0]),
      .lossIn(lossIn), .rxBit(rxBit), .rxBitStrobe(rxBitStrobe), .linkClk(linkClk),
      .signalLossStatus(signalLossStatus));

   // Clock, master clock stand-in and random data source
   always #4 mclk = ~mclk;
   always @(posedge mclk) osc <= ~osc;
   always @(posedge mclk) if (rxBitStrobe) lfsrState <= lfsr(lfsrState);

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task automatic cmp_bit(input logic got, input logic exp, input string what);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask : cmp_bit

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp_byte

   task automatic wr(input logic [7:0] ofs, input logic [7:0] d, input logic [1:0] pg = 2'h0);
      @(posedge mclk);
      regAddr <= {pg, ofs};
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge mclk);
      regWrEn <= 1'b0;
   endtask : wr

   // Read data is registered, so it is taken half a cycle after the taking edge
   task automatic rdr(input logic [7:0] ofs, input logic [1:0] pg = 2'h0);
      @(posedge mclk);
      regAddr <= {pg, ofs};
      regRdEn <= 1'b1;
      @(posedge mclk);
      regRdEn <= 1'b0;
      @(negedge mclk);
      rd = regRdData;
   endtask : rdr

   // Queue model: output is the input stream delayed by half the depth
   always @(negedge mclk) begin
      if (checking && rxBitStrobe) begin
         q.push_back(rxBit);
         inCount++;
      end
      if (checking && jaDataStrobe) begin
         outCount++;
         if (outCount > skip) cmp_bit(jaDataOut, q.size() ? q.pop_front() : 1'bx, "output bit");
      end
      if (refCheck) cmp_bit(refA, expA, "reference A");
      if (refCheck) cmp_bit(refB, expB, "reference B");
      expA = signalLossStatus[selA] ? (fb | osc) : linkClk[selA];
      expB = signalLossStatus[selB] ? (fb | osc) : linkClk[selB];
   end

   // Restart with a fresh enable edge, then stream and check distance midway
   task automatic run_case(input logic [7:0] cfg, input int nbits, input int half);
      run <= 1'b0;
      checking = 0;
      repeat (200) @(posedge mclk);
      wr(8'h27, 8'h00);
      wr(8'h27, cfg);
      q.delete();
      inCount = 0;
      outCount = 0;
      skip = half;
      checking = 1;
      run <= 1'b1;
      repeat (nbits * bitPeriod / 2) @(posedge mclk);
      rdr(8'h39);
      if (half > 0) cmp_bit((rd[6:0] + 3 - (half + inCount - outCount)) <= 6, 1'b1, "distance");
      repeat (nbits * bitPeriod / 2) @(posedge mclk);
      cmp_bit(unsigned'(inCount - outCount + 3) <= 6, 1'b1, "output count");
      checking = 0;
   endtask : run_case

   task automatic report_and_stop;
      if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   // Watchdog sized about half again above the planned run length
   initial begin
      repeat (95000) @(posedge mclk);
      failures++;
      report_and_stop();
   end

   initial begin
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      rdr(8'h27);
      cmp_byte(rd, 8'h00, "config reset");
      rdr(8'h3e);
      cmp_byte(rd, 8'h00, "ref control reset");
      rdr(8'h30);
      cmp_byte(rd, 8'h00, "unmapped read");
      wr(8'h27, 8'hff, 2'h1);
      rdr(8'h27);
      cmp_byte(rd, 8'h00, "other page write");
      // Every link choice, loss state and fallback level on both outputs
      for (int s = 0; s < 4; s++) for (int l = 0; l < 2; l++) for (int f = 0; f < 2; f++) begin
         selA = 2'(s);
         selB = 2'(3 - s);
         fb = 1'(f);
         lossIn <= l ? 4'((1 << s) | (8 >> s)) : 4'h0; // Loss on both selected links
         wr(8'h3e, {2'h0, 2'(3 - s), 2'(s), 1'b0, 1'(f)});
         repeat (3) @(negedge mclk);
         refCheck = 1'b1;
         repeat (10) @(negedge mclk);
         refCheck = 1'b0;
         rdr(8'h3b);
         cmp_bit(rd[1], lossIn[0], "loss status");
         rdr(8'h3e);
         cmp_byte(rd, {2'h0, 2'(3 - s), 2'(s), 1'b0, 1'(f)}, "ref control");
      end
      lossIn <= 4'h0;
      run_case(8'h00, 30, 0);
      run_case(8'h01, 120, 16);
      run_case(8'h0b, 120, 32);
      e1Mode <= 1'b1;
      bitPeriod <= 8'h3d;
      run_case(8'h05, 120, 64);
      run_case(8'h0f, 120, 64);
      // Writes far faster than reads must overflow and interrupt
      wr(8'h34, 8'h01);
      wr(8'h27, 8'h00);
      wr(8'h27, 8'h01);
      wr(8'h3b, 8'h01); // Start from a clear flag so the check can fail
      bitPeriod <= 8'h28;
      run <= 1'b1;
      repeat (2600) @(posedge mclk);
      rdr(8'h3b);
      cmp_bit(rd[0], 1'b1, "overflow flag");
      cmp_bit(irqN, 1'b0, "interrupt low");
      wr(8'h34, 8'h00);
      repeat (2) @(negedge mclk);
      cmp_bit(irqN, 1'b1, "interrupt masked");
      run <= 1'b0;
      wr(8'h3b, 8'h01);
      rdr(8'h3b);
      cmp_bit(rd[0], 1'b0, "flag cleared");
      repeat (3000) @(posedge mclk);
      rdr(8'h3b);
      cmp_bit(rd[0], 1'b1, "underflow flag");
      // Limit function absorbs a writer that would overflow without it
      bitPeriod <= 8'h37;
      wr(8'h27, 8'h00);
      wr(8'h27, 8'h11);
      run <= 1'b1;
      wr(8'h3b, 8'h01);
      repeat (13000) @(posedge mclk);
      rdr(8'h3b);
      cmp_bit(rd[0], 1'b0, "limit keeps flow");
      // Peak hold never decreases
      bitPeriod <= 8'h3d;
      wr(8'h27, 8'h00);
      wr(8'h27, 8'h23);
      prev = 7'h20;
      repeat (5) begin
         repeat (1200) @(posedge mclk);
         rdr(8'h39);
         cmp_bit(rd[6:0] >= prev, 1'b1, "peak hold");
         prev = rd[6:0];
      end
      report_and_stop();
   end
endmodule : test_receive_jitter_attenuator
